// ### src/nvac_ctrl.sv
// Flash access control: APB registers, read wait states, sleep, page writes
`timescale 1ns/10ps
`include "nvac_defines.svh"
module nvac_ctrl (
    input wire logic core_clk, // System clock, 40 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic [11:0] paddr, // APB address
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic sys_sleep, // System is in sleep
    input wire nvac_pkg::nvac_rd_req_s rd_req, // Master read request
    output logic rd_ack, // Read data valid, one cycle
    output logic [31:0] rd_data, // Read data
    input wire nvac_pkg::nvac_pb_wr_s pb_wr, // Page-buffer word write
    output nvac_pkg::nvac_flash_s fl, // Flash array controls
    input wire logic [31:0] fl_rd_data // Flash array read data
);
    import nvac_pkg::*;

    logic [3:0] wait_states_r, wait_states_nxt;
    logic manual_wr_r, manual_wr_nxt;
    logic [1:0] slp_r, slp_nxt;
    logic [1:0] cache_r, cache_nxt;
    logic [21:0] addr_r, addr_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic cmd_wp;
    nvac_rd_state_e st_r, st_nxt;
    nvac_flash_s fl_r, fl_nxt;
    logic rd_ack_r, rd_ack_nxt;
    logic [31:0] rd_data_r, rd_data_nxt;
    logic sleep_q_r;
    logic take;
    logic [3:0] eff_waits;
    logic expired;

    function automatic logic is_mapped(input logic [11:0] a);
        return a == `NVAC_OFS_CMD || a == `NVAC_OFS_CFG ||
            a == `NVAC_OFS_STAT || a == `NVAC_OFS_ADDR;
    endfunction

    function automatic logic is_last_word(input logic [21:0] a);
        return &a[`NVAC_PAGE_W-1:0];
    endfunction

    wire apb_wr = psel & penable & pready_r & pwrite;
    wire apb_setup = psel & ~penable;

    // Register group: one-cycle access phase, pready from a flop
    always_comb begin
        wait_states_nxt = wait_states_r;
        manual_wr_nxt = manual_wr_r;
        slp_nxt = slp_r;
        cache_nxt = cache_r;
        addr_nxt = addr_r;
        prdata_nxt = 32'h0;
        pready_nxt = apb_setup;
        pslverr_nxt = apb_setup & ~is_mapped(paddr);
        cmd_wp = 1'b0;
        if (apb_setup && !pwrite) begin
            unique case (paddr)
                `NVAC_OFS_CFG: begin
                    prdata_nxt[`NVAC_WAIT_MSB:`NVAC_WAIT_LSB] = wait_states_r;
                    prdata_nxt[`NVAC_MANUAL_BIT] = manual_wr_r;
                    prdata_nxt[`NVAC_SLP_MSB:`NVAC_SLP_LSB] = slp_r;
                    prdata_nxt[`NVAC_CACHE_MSB:`NVAC_CACHE_LSB] = cache_r;
                end
                `NVAC_OFS_STAT: begin
                    prdata_nxt[`NVAC_STAT_LP_BIT] = fl_r.lowpower;
                    prdata_nxt[`NVAC_STAT_BUSY_BIT] = (st_r != NVAC_IDLE);
                end
                `NVAC_OFS_ADDR: prdata_nxt[`NVAC_ADDR_W-1:0] = addr_r;
                default: prdata_nxt = 32'h0;
            endcase
        end
        if (apb_wr && paddr == `NVAC_OFS_CFG) begin
            wait_states_nxt = pwdata[`NVAC_WAIT_MSB:`NVAC_WAIT_LSB];
            manual_wr_nxt = pwdata[`NVAC_MANUAL_BIT];
            // Reserved encodings are refused so the mode stays defined
            if (pwdata[`NVAC_SLP_MSB:`NVAC_SLP_LSB] != `NVAC_SLP_RSVD) begin
                slp_nxt = pwdata[`NVAC_SLP_MSB:`NVAC_SLP_LSB];
            end
            if (pwdata[`NVAC_CACHE_MSB:`NVAC_CACHE_LSB] != `NVAC_CACHE_RSVD)
            begin
                cache_nxt = pwdata[`NVAC_CACHE_MSB:`NVAC_CACHE_LSB];
            end
        end
        if (apb_wr && paddr == `NVAC_OFS_ADDR) begin
            addr_nxt = pwdata[`NVAC_ADDR_W-1:0];
        end
        if (apb_wr && paddr == `NVAC_OFS_CMD &&
            pwdata[`NVAC_KEY_MSB:`NVAC_KEY_LSB] == `NVAC_KEY &&
            pwdata[`NVAC_CMD_MSB:0] == `NVAC_CMD_WP) begin
            cmd_wp = 1'b1;
        end
        // Hardware page-buffer tracking wins over a software address write
        if (pb_wr.valid) begin
            addr_nxt = pb_wr.addr;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wait_states_r <= `NVAC_WAIT_RST;
            manual_wr_r <= `NVAC_MANUAL_RST;
            slp_r <= `NVAC_SLP_RST;
            cache_r <= `NVAC_CACHE_RST;
            addr_r <= 22'h0;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            wait_states_r <= wait_states_nxt;
            manual_wr_r <= manual_wr_nxt;
            slp_r <= slp_nxt;
            cache_r <= cache_nxt;
            addr_r <= addr_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign take = (st_r == NVAC_IDLE) && rd_req.valid && !fl_r.lowpower;

    nvac_wait_timer u_timer (
        .core_clk(core_clk),
        .srst(srst),
        .start(take),
        .hit(rd_req.hit),
        .cache_mode(cache_r),
        .wait_states(wait_states_r),
        .eff_waits(eff_waits),
        .expired(expired)
    );

    // Read, power and program group
    always_comb begin
        st_nxt = st_r;
        fl_nxt = fl_r;
        fl_nxt.prog = 1'b0;
        rd_ack_nxt = 1'b0;
        rd_data_nxt = rd_data_r;
        unique case (st_r)
            NVAC_IDLE: begin
                if (take) begin
                    st_nxt = NVAC_READ;
                    fl_nxt.rd_en = 1'b1;
                    fl_nxt.addr = rd_req.addr;
                end
            end
            NVAC_READ: begin
                if (expired) begin
                    st_nxt = NVAC_ACK;
                    fl_nxt.rd_en = 1'b0;
                    rd_ack_nxt = 1'b1;
                    rd_data_nxt = fl_rd_data;
                end
            end
            NVAC_ACK: st_nxt = NVAC_IDLE;
        endcase
        // Entering sleep drops the array to low power unless disabled
        if (sys_sleep && !sleep_q_r && slp_r != `NVAC_SLP_OFF) begin
            fl_nxt.lowpower = 1'b1;
        end else if (fl_r.lowpower) begin
            if (slp_r == `NVAC_SLP_INSTANT && !sys_sleep) begin
                fl_nxt.lowpower = 1'b0;
            end else if (slp_r == `NVAC_SLP_ACCESS &&
                (rd_req.valid || pb_wr.valid)) begin
                fl_nxt.lowpower = 1'b0;
            end else if (slp_r == `NVAC_SLP_OFF) begin
                fl_nxt.lowpower = 1'b0;
            end
        end
        // Automatic page write has priority over a command in the same cycle
        if (pb_wr.valid && !manual_wr_r && is_last_word(pb_wr.addr)) begin
            fl_nxt.prog = 1'b1;
            fl_nxt.addr = pb_wr.addr;
        end else if (cmd_wp && st_r == NVAC_IDLE && !take) begin
            fl_nxt.prog = 1'b1;
            fl_nxt.addr = addr_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_r <= NVAC_IDLE;
            fl_r <= '0;
            rd_ack_r <= 1'b0;
            rd_data_r <= 32'h0;
            sleep_q_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            fl_r <= fl_nxt;
            rd_ack_r <= rd_ack_nxt;
            rd_data_r <= rd_data_nxt;
            sleep_q_r <= sys_sleep;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign rd_ack = rd_ack_r;
    assign rd_data = rd_data_r;
    assign fl = fl_r;

    // Helper: counts read-phase cycles against the latched wait count
    logic [4:0] obs_cnt_r;
    logic [3:0] obs_w_r;
    always_ff @(posedge core_clk) begin
        if (srst || take) begin
            obs_cnt_r <= 5'h0;
        end else if (st_r == NVAC_READ) begin
            obs_cnt_r <= obs_cnt_r + 5'h1;
        end
        if (take) begin
            obs_w_r <= eff_waits;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    read_wait_count_a:
    assert property (rd_ack_r |-> obs_cnt_r == {1'b0, obs_w_r} + 5'h1)
        else $error("read ack not after programmed wait states");
    det_equal_time_a:
    assert property (take && cache_r == `NVAC_CACHE_DET
        |-> eff_waits == wait_states_r)
        else $error("deterministic mode hit used other wait count");
    sleep_enter_lp_a:
    assert property ($rose(sys_sleep) && slp_r == `NVAC_SLP_ACCESS
        |=> fl_r.lowpower && !fl_r.rd_en)
        else $error("array not in low power after sleep entry");
    wake_instant_a:
    assert property (fl_r.lowpower && slp_r == `NVAC_SLP_INSTANT &&
        !sys_sleep && !$rose(sys_sleep) |=> !fl_r.lowpower)
        else $error("array did not wake on sleep exit");
    power_off_mode_a:
    assert property (slp_r == `NVAC_SLP_OFF |=> !fl_r.lowpower)
        else $error("power reduction while disabled");
    auto_page_prog_a:
    assert property (pb_wr.valid && !manual_wr_r && is_last_word(pb_wr.addr)
        |=> fl_r.prog && fl_r.addr == $past(pb_wr.addr))
        else $error("automatic page write missing");
    manual_no_auto_a:
    assert property (pb_wr.valid && manual_wr_r && !cmd_wp |=> !fl_r.prog)
        else $error("automatic write in manual mode");
    reset_values_a:
    assert property ($past(srst) |-> manual_wr_r &&
        wait_states_r == `NVAC_WAIT_RST)
        else $error("bad reset of configuration");
    addr_follow_a:
    assert property (pb_wr.valid |=> addr_r == $past(pb_wr.addr))
        else $error("address did not follow page buffer");
    addr_high_zero_a:
    assert property (pready_r && !$past(pwrite) &&
        $past(paddr) == `NVAC_OFS_ADDR
        |-> prdata_r == {10'h0, $past(addr_r)})
        else $error("address read back not zero extended");

    auto_prog_c: cover property (fl_r.prog && !manual_wr_r);
    cmd_prog_c: cover property (cmd_wp ##1 fl_r.prog);
    access_wake_c: cover property (fl_r.lowpower ##1 !fl_r.lowpower);
    max_wait_c: cover property (rd_ack_r && obs_w_r == 4'hf);
endmodule // nvac_ctrl

// ### src/nvac_defines.svh
// Register map, field positions and reset values of the flash access control
//
// Functional notes
// - Cache mode 0x2: hit and miss take programmed waits; 0x3 reserved.
// - Sleep mode 0x0: low power on sleep entry, wake on first access.
// - Sleep mode 0x1: low power on sleep entry, wake when sleep ends.
// - Sleep mode 0x3: no automatic power reduction; 0x2 reserved.
// - Manual write 0: writing last page-buffer word programs that page.
// - Manual write 1: programming only by explicit write command.
// - Manual write select resets to 1.
// - Each flash read inserts the 4-bit wait-state count, 0 to 15; a hit skips it except in cache mode 0x2.
// - Read wait-state field resets to zero.
// - 22-bit address feeds commands and follows page-buffer writes.
`ifndef NVAC_DEFINES_SVH
`define NVAC_DEFINES_SVH

`define NVAC_APB_AW 12
`define NVAC_OFS_CMD 12'h000
`define NVAC_OFS_CFG 12'h004
`define NVAC_OFS_STAT 12'h018
`define NVAC_OFS_ADDR 12'h01c

`define NVAC_WAIT_MSB 4
`define NVAC_WAIT_LSB 1
`define NVAC_MANUAL_BIT 7
`define NVAC_STAT_LP_BIT 0
`define NVAC_STAT_BUSY_BIT 1
`define NVAC_SLP_MSB 9
`define NVAC_SLP_LSB 8
`define NVAC_CACHE_MSB 17
`define NVAC_CACHE_LSB 16
`define NVAC_KEY_MSB 15
`define NVAC_KEY_LSB 8
`define NVAC_CMD_MSB 6

`define NVAC_CACHE_DET 2'h2
`define NVAC_CACHE_RSVD 2'h3
`define NVAC_SLP_ACCESS 2'h0
`define NVAC_SLP_INSTANT 2'h1
`define NVAC_SLP_RSVD 2'h2
`define NVAC_SLP_OFF 2'h3
`define NVAC_KEY 8'ha5
`define NVAC_CMD_WP 7'h04

`define NVAC_ADDR_W 22
`define NVAC_PAGE_W 5
`define NVAC_WAIT_RST 4'h0
`define NVAC_MANUAL_RST 1'b1
`define NVAC_SLP_RST 2'h0
`define NVAC_CACHE_RST 2'h0

`endif

// ### src/nvac_pkg.sv
// Types shared by the flash access control files
package nvac_pkg;
    typedef enum logic [1:0] {
        NVAC_IDLE,
        NVAC_READ,
        NVAC_ACK
    } nvac_rd_state_e;

    typedef struct packed {
        logic valid;
        logic hit;
        logic [21:0] addr;
    } nvac_rd_req_s;

    typedef struct packed {
        logic valid;
        logic [21:0] addr;
    } nvac_pb_wr_s;

    typedef struct packed {
        logic rd_en;
        logic prog;
        logic lowpower;
        logic [21:0] addr;
    } nvac_flash_s;
endpackage

// ### src/nvac_wait_timer.sv
// Read wait-state counter with cache-mode timing selection
`timescale 1ns/10ps
`include "nvac_defines.svh"
module nvac_wait_timer (
    input wire logic core_clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic start, // Load on read take
    input wire logic hit, // Cache hit on this read
    input wire logic [1:0] cache_mode, // Cache timing mode
    input wire logic [3:0] wait_states, // Programmed wait states
    output logic [3:0] eff_waits, // Waits chosen for this read
    output logic expired // Count has reached zero
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;

    // Outside deterministic mode a hit bypasses the array wait states
    always_comb begin
        if (hit && cache_mode != `NVAC_CACHE_DET) begin
            eff_waits = 4'h0;
        end else begin
            eff_waits = wait_states;
        end
    end

    always_comb begin
        cnt_nxt = cnt_r;
        if (start) begin
            cnt_nxt = eff_waits;
        end else if (cnt_r != 4'h0) begin
            cnt_nxt = cnt_r - 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign expired = (cnt_r == 4'h0);
endmodule // nvac_wait_timer

// ### dv/nvac_flash_model.sv
// Behavioural flash array model answering the controller's read enable
`timescale 1ns/10ps
module nvac_flash_model (
    input wire logic core_clk, // System clock
    input wire nvac_pkg::nvac_flash_s fl, // Array controls
    output logic [31:0] fl_rd_data // Array read data
);
    import nvac_pkg::*;
    // Outside a read the bus wanders every cycle, so a late sample shows
    logic [31:0] junk_r = 32'h5a5a5a5a;
    always @(posedge core_clk) begin
        junk_r <= ~junk_r;
    end
    assign fl_rd_data = fl.rd_en ? {fl.addr, 10'h155} : junk_r;
endmodule // nvac_flash_model

// ### dv/nvac_ctrl_test.sv
// Self-checking bench for the flash access control block
`timescale 1ns/10ps
`include "nvac_defines.svh"
module nvac_ctrl_test;
    import nvac_pkg::*;
    logic core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
    logic sys_sleep = 0, pready, pslverr, rd_ack, er;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd_data, fl_rd_data, rv;
    logic [31:0] seed = 32'd3338;
    logic [21:0] a;
    logic [1:0] sm[3] = '{2'h3, 2'h1, 2'h0};
    int wl[4] = '{0, 1, 15, 6};
    nvac_rd_req_s rd_req = '0;
    nvac_pb_wr_s pb_wr = '0;
    nvac_flash_s fl;
    int n_errors = 0, n_checks = 0;
    logic [31:0] rd_q[$];
    logic [21:0] pg_q[$];

    nvac_ctrl i_dut (.core_clk(core_clk), .srst(srst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sys_sleep(sys_sleep), .rd_req(rd_req), .rd_ack(rd_ack),
        .rd_data(rd_data), .pb_wr(pb_wr), .fl(fl), .fl_rd_data(fl_rd_data));
    nvac_flash_model i_flash (.core_clk(core_clk), .fl(fl),
        .fl_rd_data(fl_rd_data));

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    function automatic logic [21:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[21:0];
    endfunction

    function automatic logic [31:0] cfgv(logic [3:0] w, logic m,
        logic [1:0] s, logic [1:0] c);
        return {14'h0, c, 6'h0, s, m, 2'h0, w, 1'b0};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic hang();
        n_errors++;
        $display("[FAIL] %0t wait limit reached", $time);
        end_sim();
    endtask

    task automatic apb(input logic w, input logic [11:0] ad,
        input logic [31:0] d);
        int i;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) hang();
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // A negative wait count skips the latency check (wake from low power)
    task automatic rd(input logic h, input logic [21:0] ad, input int w);
        int n;
        @(posedge core_clk);
        rd_req <= '{1'b1, h, ad};
        rd_q.push_back({ad, 10'h155});
        for (n = 1; n <= 40; n++) begin
            @(posedge core_clk);
            if (rd_ack === 1'b1) break;
        end
        rd_req.valid <= 1'b0;
        if (n > 40) hang();
        if (w >= 0) check(n, w + 3);
    endtask

    task automatic pb(input logic [21:0] ad, input logic p);
        @(posedge core_clk);
        pb_wr <= '{1'b1, ad};
        if (p) pg_q.push_back(ad);
        @(posedge core_clk);
        pb_wr.valid <= 1'b0;
    endtask

    // Results are matched against the oldest note of the driver
    always @(posedge core_clk) begin
        if (rd_ack === 1'b1) begin
            if (rd_q.size() == 0) check(1, 0);
            else check(rd_data, rd_q.pop_front());
        end
        if (fl.prog === 1'b1) begin
            if (pg_q.size() == 0) check(1, 0);
            else check(fl.addr, pg_q.pop_front());
        end
    end

    initial begin
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        apb(0, `NVAC_OFS_CFG, 0);
        check(rv & 32'h3039e, 32'h80);
        apb(0, `NVAC_OFS_ADDR, 0);
        check(rv, 0);
        a = rnd();
        apb(1, `NVAC_OFS_ADDR, {10'h3ff, a});
        apb(0, `NVAC_OFS_ADDR, 0);
        check(rv, {10'h0, a});
        apb(0, 12'h100, 0);
        check(er, 1);
        $display("test registers done");
        foreach (wl[k]) begin
            apb(1, `NVAC_OFS_CFG, cfgv(wl[k], 1, 3, 0));
            rd(0, rnd(), wl[k]);
            rd(1, rnd(), 0);
            apb(1, `NVAC_OFS_CFG, cfgv(wl[k], 1, 3, 2));
            rd(1, rnd(), wl[k]);
        end
        apb(1, `NVAC_OFS_CFG, cfgv(0, 1, 3, 3));
        apb(0, `NVAC_OFS_CFG, 0);
        check(rv & 32'h3039e, cfgv(0, 1, 3, 2));
        $display("test wait states done");
        apb(1, `NVAC_OFS_CFG, cfgv(0, 0, 3, 0));
        a = rnd() | 22'h1f;
        pb(a, 1);
        pb(a ^ 22'h1, 0);
        apb(0, `NVAC_OFS_ADDR, 0);
        check(rv, {10'h0, a ^ 22'h1});
        apb(1, `NVAC_OFS_CFG, cfgv(0, 1, 3, 0));
        pb(a, 0);
        pg_q.push_back(a);
        apb(1, `NVAC_OFS_CMD, 32'ha504);
        // A wrong key must not program; the monitor flags any pulse
        apb(1, `NVAC_OFS_CMD, 32'h5a04);
        repeat (3) @(posedge core_clk);
        check(pg_q.size(), 0);
        $display("test page writes done");
        foreach (sm[k]) begin
            apb(1, `NVAC_OFS_CFG, cfgv(0, 1, sm[k], 0));
            sys_sleep <= 1'b1;
            repeat (3) @(posedge core_clk);
            check(fl.lowpower, sm[k] != 2'h3);
            apb(0, `NVAC_OFS_STAT, 0);
            check(rv[0], sm[k] != 2'h3);
            sys_sleep <= 1'b0;
            repeat (3) @(posedge core_clk);
            check(fl.lowpower, sm[k] == 2'h0);
            if (sm[k] == 2'h0) rd(0, rnd(), -1);
            check(fl.lowpower, 0);
        end
        apb(1, `NVAC_OFS_CFG, cfgv(0, 1, 2, 0));
        apb(0, `NVAC_OFS_CFG, 0);
        check(rv & 32'h3039e, cfgv(0, 1, 0, 0));
        $display("test sleep done");
        check(rd_q.size(), 0);
        end_sim();
    end
endmodule // nvac_ctrl_test
